// [hw/rri_defines.svh]
// Timing and layout constants of the release interlock
`ifndef RRI_DEFINES_SVH
`define RRI_DEFINES_SVH
`define RRI_CLK_HZ        25000000
`define RRI_MS_CYCLES     (`RRI_CLK_HZ / 1000)
`define RRI_ACK_MIN_SHORT_MS 100
`define RRI_ACK_MIN_LONG_MS  350
`define RRI_ACK_MAX_MS    30000
`define RRI_BLINK_HALF_MS 500
`define RRI_MAX_CONTACTS  7
`define RRI_MS_W          15
`endif

// [hw/rri_pkg.sv]
// Types of the release interlock
package rri_pkg;
  typedef enum logic [2:0] {
    RRI_IDLE    = 3'b001,
    RRI_WAIT    = 3'b010,
    RRI_RELEASE = 3'b100
  } rri_state_e;

  typedef struct packed {
    logic cond_met;
    logic restart_req;
    logic release_on;
  } rri_out_s;
endpackage : rri_pkg

// [hw/rri_ms_tick.sv]
// Millisecond enable divider
`timescale 1ns/100ps
`include "rri_defines.svh"
module rri_ms_tick #(
  parameter int DIV = `RRI_MS_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;

  always_comb begin
    if (cnt == 16'(DIV - 1)) begin
      next_cnt = 16'h0;
    end else begin
      next_cnt = cnt + 16'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt  <= 16'h0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= (cnt == 16'(DIV - 1));
    end
  end
endmodule : rri_ms_tick

// [hw/rri_interlock.sv]
// Release interlock with acknowledge pulse timing and restart lamp
`timescale 1ns/100ps
`include "rri_defines.svh"
// Contract
// - Accepts one to seven activated contact inputs beside the acknowledge input.
// - Condition-met is the AND of all activated contacts.
// - Release rises after valid acknowledge pulse while condition is met.
// - Minimum acknowledge length selectable: 100 ms or 350 ms.
// - Acknowledge shorter than minimum or longer than 30 s is ignored.
// - Release drops as soon as any activated contact goes low.
module rri_interlock #(
  parameter int MS_DIV  = `RRI_MS_CYCLES,
  parameter int MAX_CON = `RRI_MAX_CONTACTS
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [MAX_CON-1:0]   contact,
  input  wire logic [2:0]           contact_input_count,
  input  wire logic                 ack,
  input  wire logic                 ack_min_long,
  output rri_pkg::rri_out_s         status
);
  import rri_pkg::*;

  localparam logic [`RRI_MS_W-1:0] MIN_SHORT = `RRI_MS_W'(`RRI_ACK_MIN_SHORT_MS);
  localparam logic [`RRI_MS_W-1:0] MIN_LONG  = `RRI_MS_W'(`RRI_ACK_MIN_LONG_MS);
  localparam logic [`RRI_MS_W-1:0] MAX_ACK   = `RRI_MS_W'(`RRI_ACK_MAX_MS);
  localparam logic [`RRI_MS_W-1:0] HALF_1HZ  = `RRI_MS_W'(`RRI_BLINK_HALF_MS);

  logic                  ms_tick;
  logic [MAX_CON-1:0]    active;
  logic                  cond;
  rri_state_e            state;
  rri_state_e            next_state;
  logic [`RRI_MS_W-1:0]  ack_ms;
  logic [`RRI_MS_W-1:0]  next_ack_ms;
  logic                  ack_q;
  logic                  ack_valid;
  logic [`RRI_MS_W-1:0]  blink_ms;
  logic [`RRI_MS_W-1:0]  next_blink_ms;
  logic                  lamp;
  logic                  next_lamp;
  logic [`RRI_MS_W-1:0]  min_ms;

  rri_ms_tick #(.DIV(MS_DIV)) u_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (ms_tick)
  );

  genvar gi;
  generate
    for (gi = 0; gi < MAX_CON; gi++) begin : g_act
      assign active[gi] = contact[gi] | (3'(gi) >= contact_input_count);
    end
  endgenerate

  assign cond = (contact_input_count != 3'h0) && (&active);

  assign min_ms = ack_min_long ? MIN_LONG : MIN_SHORT;

  always_comb begin
    next_ack_ms = ack_ms;
    ack_valid   = 1'b0;
    if (ack) begin
      if (ms_tick && ack_ms <= MAX_ACK) begin
        next_ack_ms = ack_ms + `RRI_MS_W'(1);
      end
    end else begin
      next_ack_ms = '0;
      ack_valid   = ack_q && (ack_ms >= min_ms) && (ack_ms <= MAX_ACK);
    end
  end

  always_comb begin
    case (state)
      RRI_IDLE: begin
        next_state = cond ? RRI_WAIT : RRI_IDLE;
      end
      RRI_WAIT: begin
        if (!cond) begin
          next_state = RRI_IDLE;
        end else if (ack_valid) begin
          next_state = RRI_RELEASE;
        end else begin
          next_state = RRI_WAIT;
        end
      end
      RRI_RELEASE: begin
        next_state = cond ? RRI_RELEASE : RRI_IDLE;
      end
      default: begin
        next_state = RRI_IDLE;
      end
    endcase
  end

  always_comb begin
    next_blink_ms = blink_ms;
    next_lamp     = lamp;
    if (next_state != RRI_WAIT) begin
      next_blink_ms = '0;
      next_lamp     = 1'b0;
    end else if (state != RRI_WAIT) begin
      next_blink_ms = '0;
      next_lamp     = 1'b1;
    end else if (ms_tick) begin
      if (blink_ms == HALF_1HZ - `RRI_MS_W'(1)) begin
        next_blink_ms = '0;
        next_lamp     = ~lamp;
      end else begin
        next_blink_ms = blink_ms + `RRI_MS_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= RRI_IDLE;
      ack_ms   <= '0;
      ack_q    <= 1'b0;
      blink_ms <= '0;
      lamp     <= 1'b0;
    end else begin
      state    <= next_state;
      ack_ms   <= next_ack_ms;
      ack_q    <= ack;
      blink_ms <= next_blink_ms;
      lamp     <= next_lamp;
    end
  end

  assign status.cond_met    = cond;
  assign status.release_on  = (state == RRI_RELEASE) && cond;
  assign status.restart_req = lamp && (state == RRI_WAIT) && cond;

  property p_drop;
    @(posedge clk) disable iff (rst)
      (state == RRI_RELEASE && !cond) |-> !status.release_on ##1 (state == RRI_IDLE);
  endproperty
  a_drop: assert property (p_drop) else $error("release high with condition low");

  property p_rise;
    @(posedge clk) disable iff (rst)
      (state == RRI_WAIT && cond && ack_valid) |=> (state == RRI_RELEASE);
  endproperty
  a_rise: assert property (p_rise) else $error("valid acknowledge did not release");

  property p_no_ack;
    @(posedge clk) disable iff (rst)
      (state == RRI_WAIT && !ack_valid) |=> (state != RRI_RELEASE);
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("release without valid acknowledge");

  property p_idle_hold;
    @(posedge clk) disable iff (rst) (state == RRI_IDLE) |=> (state != RRI_RELEASE);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("release entered from idle");

  property p_rel_hold;
    @(posedge clk) disable iff (rst) (state == RRI_RELEASE && cond) |=> (state == RRI_RELEASE);
  endproperty
  a_rel_hold: assert property (p_rel_hold) else $error("release lost with condition met");

  property p_short;
    @(posedge clk) disable iff (rst)
      (ack_q && !ack && ack_ms < min_ms) |-> !ack_valid;
  endproperty
  a_short: assert property (p_short) else $error("short acknowledge accepted");

  property p_long;
    @(posedge clk) disable iff (rst) (ack_ms > MAX_ACK) |-> !ack_valid;
  endproperty
  a_long: assert property (p_long) else $error("overlong acknowledge accepted");

  property p_min_sel;
    @(posedge clk) disable iff (rst)
      (ack_q && !ack && ack_ms == MIN_SHORT && !ack_min_long) |-> ack_valid;
  endproperty
  a_min_sel: assert property (p_min_sel) else $error("minimum pulse not accepted");

  property p_lamp_off;
    @(posedge clk) disable iff (rst) (state != RRI_WAIT) |-> !status.restart_req;
  endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("lamp on outside wait");

  property p_lamp_start;
    @(posedge clk) disable iff (rst) (state == RRI_IDLE && cond) |=> (state == RRI_WAIT && lamp);
  endproperty
  a_lamp_start: assert property (p_lamp_start) else $error("lamp not lit on entering wait");

  property p_blink_hold;
    @(posedge clk) disable iff (rst)
      (state == RRI_WAIT && next_state == RRI_WAIT && !(ms_tick && blink_ms == HALF_1HZ - `RRI_MS_W'(1)))
      |=> $stable(lamp);
  endproperty
  a_blink_hold: assert property (p_blink_hold) else $error("lamp changed inside half period");

  property p_blink;
    @(posedge clk) disable iff (rst)
      (state == RRI_WAIT && $past(state) == RRI_WAIT && ms_tick && blink_ms == HALF_1HZ - `RRI_MS_W'(1)
       && next_state == RRI_WAIT) |=> (lamp != $past(lamp));
  endproperty
  a_blink: assert property (p_blink) else $error("lamp did not toggle at half period");

  property p_and;
    @(posedge clk) disable iff (rst)
      (contact_input_count != 3'h0 && !contact[0]) |-> !status.cond_met;
  endproperty
  a_and: assert property (p_and) else $error("condition met with a contact open");

  property p_cnt_zero;
    @(posedge clk) disable iff (rst) (contact_input_count == 3'h0) |-> !status.cond_met;
  endproperty
  a_cnt_zero: assert property (p_cnt_zero) else $error("condition met with no contacts");
endmodule : rri_interlock

// [verification/rri_operator.sv]
// Contact and pushbutton model for the release interlock
`timescale 1ns/100ps
module rri_operator #(
  parameter int MS_DIV = 2
) (
  input  wire logic  clk,
  output logic [6:0] contact,
  output logic       ack
);
  initial begin
    contact = 7'h00;
    ack     = 1'b0;
  end
  // Button held for whole ms
  task automatic press(input int ms);
    @(negedge clk) ack = 1'b1;
    repeat (ms * MS_DIV) @(negedge clk);
    ack = 1'b0;
  endtask : press
  task automatic set_contacts(input logic [6:0] val);
    @(negedge clk) contact = val;
  endtask : set_contacts
endmodule : rri_operator

// [verification/tb_top.sv]
// Self-checking bench for the release interlock
`timescale 1ns/100ps
module tb_top;
  import rri_pkg::*;
  localparam int MS = 2;
  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] con;
    logic       cond;
  } rri_row_s;
  logic       clk = 1'b0;
  logic       rst;
  logic [2:0] cnt;
  logic       lng;
  logic [6:0] contact;
  logic       ack;
  rri_out_s   status;
  int         error_cnt = 0;
  int         n_tests = 0;
  rri_row_s   rows [7] = '{'{3'h1, 7'h01, 1'b1}, '{3'h3, 7'h07, 1'b1}, '{3'h3, 7'h05, 1'b0},
                           '{3'h7, 7'h7f, 1'b1}, '{3'h7, 7'h3f, 1'b0}, '{3'h0, 7'h7f, 1'b0},
                           '{3'h2, 7'h7c, 1'b0}};
  always #20 clk = ~clk;
  rri_operator #(.MS_DIV(MS)) i_rri_operator (.clk(clk), .contact(contact), .ack(ack));
  rri_interlock #(.MS_DIV(MS), .MAX_CON(7)) i_rri_interlock (.clk(clk), .rst(rst), .contact(contact),
    .contact_input_count(cnt), .ack(ack), .ack_min_long(lng), .status(status));
  task automatic chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic ms_wait(input int ms);
    repeat (ms * MS) @(negedge clk);
  endtask : ms_wait
  task automatic try_ack(input int ms, input logic exp);
    i_rri_operator.press(ms);
    ms_wait(2);
    chk(status.release_on, exp);
  endtask : try_ack
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #(40 * 80000);
    error_cnt++;
    final_report();
  end
  initial begin
    rst = 1'b1;
    cnt = 3'h3;
    lng = 1'b0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk(status.release_on, 1'b0);
    chk(status.restart_req, 1'b0);
    $display("reset test done");
    foreach (rows[i]) begin
      i_rri_operator.set_contacts(rows[i].con);
      cnt = rows[i].cnt;
      #1 chk(status.cond_met, rows[i].cond);
    end
    $display("condition table done");
    i_rri_operator.set_contacts(7'h07);
    cnt = 3'h3;
    ms_wait(250);
    chk(status.restart_req, 1'b1);
    ms_wait(500);
    chk(status.restart_req, 1'b0);
    $display("lamp test done");
    try_ack(80, 1'b0);
    try_ack(100, 1'b1);
    chk(status.restart_req, 1'b0);
    i_rri_operator.set_contacts(7'h05);
    #1 chk(status.release_on, 1'b0);
    i_rri_operator.set_contacts(7'h07);
    ms_wait(2);
    chk(status.release_on, 1'b0);
    chk(status.restart_req, 1'b1);
    $display("short minimum test done");
    lng = 1'b1;
    try_ack(300, 1'b0);
    try_ack(350, 1'b1);
    rst = 1'b1;
    ms_wait(1);
    chk(status.release_on, 1'b0);
    chk(status.restart_req, 1'b0);
    rst = 1'b0;
    ms_wait(2);
    chk(status.release_on, 1'b0);
    chk(status.restart_req, 1'b1);
    $display("mid-run reset test done");
    i_rri_operator.set_contacts(7'h05);
    #1 chk(status.cond_met, 1'b0);
    i_rri_operator.set_contacts(7'h07);
    lng = 1'b0;
    try_ack(30100, 1'b0);
    $display("long minimum and overlong test done");
    final_report();
  end
endmodule : tb_top
